// *** include/cc_timing_params.svh ***
`ifndef CC_TIMING_PARAMS_SVH
`define CC_TIMING_PARAMS_SVH

`define CLK_PERIOD_NS 25
`define NS_PER_MS 1_000_000
`define CNT_W 23

`define CC_SETTLE_MS_00 168
`define CC_SETTLE_MS_01 84
`define CC_SETTLE_MS_10 112
`define CC_SETTLE_MS_11 140

`define VBUS_SETTLE_MS 2

`define SRC_SHARE_PCT_00 30
`define SRC_SHARE_PCT_01 40
`define SRC_SHARE_PCT_10 50
`define SRC_SHARE_PCT_11 60

`define TOGGLE_PERIOD_MS 75
`define MGMT_READY_MS 15

`define WARMUP_DONE 2'h2
`define CNT_ZERO 23'h00_0000

`endif

// *** include/cc_timing_pkg.sv ***
package cc_timing_pkg;

    typedef enum logic [2:0] {
        ST_SAMPLE = 3'b000,
        ST_SOURCE = 3'b001,
        ST_SINK = 3'b010,
        ST_ATT_SRC = 3'b011,
        ST_ATT_SNK = 3'b100
    } link_state_t;

    typedef enum logic [1:0] {
        MODE_SOURCE = 2'b00,
        MODE_SINK = 2'b01,
        MODE_DUAL = 2'b10
    } role_mode_t;

    typedef struct packed {
        logic attached;
        logic as_sink;
        logic orient_cc2;
        logic vbus_valid;
    } cc_status_t;

endpackage : cc_timing_pkg

// *** rtl/cc_debounce.sv ***
`include "cc_timing_params.svh"

module cc_debounce #(
    parameter int WIDTH = 1,
    parameter int CNT_W = `CNT_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Raw pin levels and control
    input wire logic [WIDTH-1:0] raw_in,
    input wire logic restart_in,
    input wire logic [CNT_W-1:0] limit_in,
    // Results
    output logic [WIDTH-1:0] sync_out,
    output logic [WIDTH-1:0] value_out,
    output logic stable_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] cand_ff;
    logic [WIDTH-1:0] value_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic stable_ff;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= raw_in;
            sync_ff <= meta_ff;
        end
    end

    // Any change, or a role swap upstream, starts the interval over
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cand_ff <= '0;
            value_ff <= '0;
            cnt_ff <= `CNT_ZERO;
            stable_ff <= 1'b0;
        end
        else
        begin
            cand_ff <= sync_ff;
            if (sync_ff != cand_ff || restart_in)
            begin
                cnt_ff <= `CNT_ZERO;
                stable_ff <= 1'b0;
            end
            else if (cnt_ff < limit_in - 1'b1)
            begin
                cnt_ff <= cnt_ff + 1'b1;
            end
            else
            begin
                stable_ff <= 1'b1;
                value_ff <= cand_ff;
            end
        end
    end

    assign sync_out = sync_ff;
    assign value_out = value_ff;
    assign stable_out = stable_ff;

    property p_change_restarts;
        @(posedge clk_in) disable iff (!rst_n_in)
        (sync_ff != cand_ff) |=> (cnt_ff == `CNT_ZERO) && !stable_ff;
    endproperty
    a_change_restarts: assert property (p_change_restarts)
        else $error("debounce did not restart on change");

    property p_stable_after_full_count;
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(stable_ff) |-> $past(cnt_ff) >= limit_in - 1'b1;
    endproperty
    a_stable_after_full_count: assert property (p_stable_after_full_count)
        else $error("debounce settled before full interval");

endmodule : cc_debounce

// *** rtl/cc_timing_core.sv ***
// What this block does
// - Settle code 00 requires both CC levels stable 168 ms before acting.
// - Bus power sense counts as valid only after 2 ms continuously high.
// - Dual role with share code 00 presents source 30 percent of period.
// - One full dual-role source-sink-source cycle lasts 50 to 100 ms, typically 75.
// - Management port usable within 15 ms of enable; host waits till then.
// - No cable marker identification; attachment uses CC detection, plus valid bus power for a sink.
// - Role pin sampled once after reset or enable: high source, low sink, floating dual.
// - Sink attaches only after CC debounce and a valid bus power detection.
// - Floating role pin alternates source and sink until attachment resolves.
`include "cc_timing_params.svh"

module cc_timing_core #(
    parameter int SETTLE_CYC_00 =
        (`CC_SETTLE_MS_00 * `NS_PER_MS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int SETTLE_CYC_01 =
        (`CC_SETTLE_MS_01 * `NS_PER_MS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int SETTLE_CYC_10 =
        (`CC_SETTLE_MS_10 * `NS_PER_MS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int SETTLE_CYC_11 =
        (`CC_SETTLE_MS_11 * `NS_PER_MS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int VBUS_CYC =
        (`VBUS_SETTLE_MS * `NS_PER_MS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int PERIOD_CYC = (`TOGGLE_PERIOD_MS * `NS_PER_MS) / `CLK_PERIOD_NS,
    parameter int MGMT_CYC = (`MGMT_READY_MS * `NS_PER_MS) / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Pins
    input wire logic enable_n_in,
    input wire logic role_pin_high_in,
    input wire logic role_pin_low_in,
    input wire logic [1:0] cc_detect_in,
    input wire logic bus_power_sense_input_in,
    // Settings from the management register logic
    input wire logic [1:0] cc_settle_time_field_in,
    input wire logic [1:0] source_share_field_in,
    // Results
    output logic present_source_out,
    output logic present_sink_out,
    output logic dual_role_out,
    output cc_timing_pkg::cc_status_t status_out,
    output logic mgmt_ready_out
);

    localparam int CW = `CNT_W;
    // Synchroniser and ready register come out of the budget so the pin-to-ready time holds
    localparam int MGMT_LAST = MGMT_CYC - 3;

    logic [2:0] pin_meta_ff;
    logic [2:0] pin_sync_ff;
    logic [1:0] warm_ff;
    cc_timing_pkg::role_mode_t mode_ff;
    cc_timing_pkg::link_state_t state_ff;
    cc_timing_pkg::link_state_t nxt_state;
    logic [CW-1:0] toggle_cnt_ff;
    logic [CW-1:0] mgmt_cnt_ff;
    logic mgmt_ready_ff;
    cc_timing_pkg::cc_status_t status_ff;
    logic [1:0] cc_sync;
    logic [1:0] cc_value;
    logic cc_stable;
    logic vbus_value;
    logic vbus_sync;
    logic vbus_stable;
    logic vbus_valid;
    logic en_active;
    logic warm_done;
    logic dual;
    logic hold;
    logic counting;
    logic cc_attach;
    logic cc_gone;
    cc_timing_pkg::role_mode_t role_pick;
    cc_timing_pkg::link_state_t home;
    logic [CW-1:0] settle_lim;
    logic [CW-1:0] share_lim;

    function automatic logic [CW-1:0] settle_cycles(input logic [1:0] code);
        case (code)
            2'b00: settle_cycles = CW'(SETTLE_CYC_00);
            2'b01: settle_cycles = CW'(SETTLE_CYC_01);
            2'b10: settle_cycles = CW'(SETTLE_CYC_10);
            default: settle_cycles = CW'(SETTLE_CYC_11);
        endcase
    endfunction : settle_cycles

    function automatic logic [CW-1:0] share_cycles(input logic [1:0] code);
        case (code)
            2'b00: share_cycles = CW'(PERIOD_CYC * `SRC_SHARE_PCT_00 / 100);
            2'b01: share_cycles = CW'(PERIOD_CYC * `SRC_SHARE_PCT_01 / 100);
            2'b10: share_cycles = CW'(PERIOD_CYC * `SRC_SHARE_PCT_10 / 100);
            default: share_cycles = CW'(PERIOD_CYC * `SRC_SHARE_PCT_11 / 100);
        endcase
    endfunction : share_cycles

    // Enable and role pins: index 0 enable, 1 high, 2 low
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pin_meta_ff <= 3'h1;
            pin_sync_ff <= 3'h1;
        end
        else
        begin
            pin_meta_ff <= {role_pin_low_in, role_pin_high_in, enable_n_in};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    assign en_active = !pin_sync_ff[0];
    assign settle_lim = settle_cycles(cc_settle_time_field_in);
    assign share_lim = share_cycles(source_share_field_in);

    cc_debounce #(
        .WIDTH(2),
        .CNT_W(CW)
    ) u_cc_deb (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .raw_in(cc_detect_in),
        .restart_in(state_ff != nxt_state),
        .limit_in(settle_lim),
        .sync_out(cc_sync),
        .value_out(cc_value),
        .stable_out(cc_stable)
    );

    cc_debounce #(
        .WIDTH(1),
        .CNT_W(CW)
    ) u_vbus_deb (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .raw_in(bus_power_sense_input_in),
        .restart_in(1'b0),
        .limit_in(CW'(VBUS_CYC)),
        .sync_out(vbus_sync),
        .value_out(vbus_value),
        .stable_out(vbus_stable)
    );

    // Drops at once on a low level, rises only after the full interval
    assign vbus_valid = vbus_stable && vbus_value;

    // The pin comparators need two cycles to pass the synchroniser
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            warm_ff <= 2'h0;
        else if (!en_active)
            warm_ff <= 2'h0;
        else if (warm_ff != `WARMUP_DONE)
            warm_ff <= warm_ff + 2'h1;
    end

    assign warm_done = (warm_ff == `WARMUP_DONE);
    assign role_pick = pin_sync_ff[1] ? cc_timing_pkg::MODE_SOURCE :
                       pin_sync_ff[2] ? cc_timing_pkg::MODE_SINK :
                       cc_timing_pkg::MODE_DUAL;

    // Role is taken once per reset or enable and then held
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            mode_ff <= cc_timing_pkg::MODE_SOURCE;
        else if (state_ff == cc_timing_pkg::ST_SAMPLE && warm_done)
            mode_ff <= role_pick;
    end

    assign dual = (mode_ff == cc_timing_pkg::MODE_DUAL);
    // Partner termination only; no cable marker query exists
    assign cc_attach = cc_stable && (|cc_value);
    assign cc_gone = cc_stable && !(|cc_value);
    // A partner seen mid-toggle freezes the swap so the settle can finish
    assign hold = |cc_sync;
    assign counting = dual && !hold &&
                      (state_ff == cc_timing_pkg::ST_SOURCE ||
                       state_ff == cc_timing_pkg::ST_SINK);
    assign home = (mode_ff == cc_timing_pkg::MODE_SINK) ?
                  cc_timing_pkg::ST_SINK : cc_timing_pkg::ST_SOURCE;

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            cc_timing_pkg::ST_SAMPLE:
                if (warm_done)
                    nxt_state = (role_pick == cc_timing_pkg::MODE_SINK) ?
                                cc_timing_pkg::ST_SINK : cc_timing_pkg::ST_SOURCE;
            cc_timing_pkg::ST_SOURCE:
                if (cc_attach)
                    nxt_state = cc_timing_pkg::ST_ATT_SRC;
                else if (counting && toggle_cnt_ff == share_lim - 1'b1)
                    nxt_state = cc_timing_pkg::ST_SINK;
            cc_timing_pkg::ST_SINK:
                if (cc_attach && vbus_valid)
                    nxt_state = cc_timing_pkg::ST_ATT_SNK;
                else if (counting && toggle_cnt_ff == CW'(PERIOD_CYC - 1))
                    nxt_state = cc_timing_pkg::ST_SOURCE;
            cc_timing_pkg::ST_ATT_SRC:
                if (cc_gone)
                    nxt_state = home;
            cc_timing_pkg::ST_ATT_SNK:
                if (cc_gone || !vbus_valid)
                    nxt_state = home;
            default:
                nxt_state = cc_timing_pkg::ST_SAMPLE;
        endcase
        if (!en_active)
            nxt_state = cc_timing_pkg::ST_SAMPLE;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            state_ff <= cc_timing_pkg::ST_SAMPLE;
        else
            state_ff <= nxt_state;
    end

    // Source share sits at the start of every period
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            toggle_cnt_ff <= `CNT_ZERO;
        else if (!counting || nxt_state != state_ff &&
                 nxt_state != cc_timing_pkg::ST_SINK &&
                 nxt_state != cc_timing_pkg::ST_SOURCE)
            toggle_cnt_ff <= hold ? toggle_cnt_ff : `CNT_ZERO;
        else if (toggle_cnt_ff == CW'(PERIOD_CYC - 1))
            toggle_cnt_ff <= `CNT_ZERO;
        else
            toggle_cnt_ff <= toggle_cnt_ff + 1'b1;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mgmt_cnt_ff <= `CNT_ZERO;
            mgmt_ready_ff <= 1'b0;
        end
        else if (!en_active)
        begin
            mgmt_cnt_ff <= `CNT_ZERO;
            mgmt_ready_ff <= 1'b0;
        end
        else if (mgmt_cnt_ff == CW'(MGMT_LAST))
            mgmt_ready_ff <= 1'b1;
        else
            mgmt_cnt_ff <= mgmt_cnt_ff + 1'b1;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            status_ff <= '0;
        else
        begin
            status_ff.attached <= (nxt_state == cc_timing_pkg::ST_ATT_SRC ||
                                   nxt_state == cc_timing_pkg::ST_ATT_SNK);
            status_ff.as_sink <= (nxt_state == cc_timing_pkg::ST_ATT_SNK);
            status_ff.vbus_valid <= vbus_valid;
            if (cc_attach && state_ff != nxt_state)
                status_ff.orient_cc2 <= cc_value[1];
        end
    end

    assign present_source_out = (state_ff == cc_timing_pkg::ST_SOURCE ||
                                 state_ff == cc_timing_pkg::ST_ATT_SRC);
    assign present_sink_out = (state_ff == cc_timing_pkg::ST_SINK ||
                               state_ff == cc_timing_pkg::ST_ATT_SNK);
    assign dual_role_out = dual && (state_ff != cc_timing_pkg::ST_SAMPLE);
    assign status_out = status_ff;
    assign mgmt_ready_out = mgmt_ready_ff;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    property p_src_attach_settled;
        state_ff == cc_timing_pkg::ST_SOURCE && nxt_state == cc_timing_pkg::ST_ATT_SRC
            |-> cc_stable && (|cc_value);
    endproperty
    a_src_attach_settled: assert property (p_src_attach_settled)
        else $error("source attach without settled CC");

    property p_snk_attach_vbus;
        $rose(status_ff.as_sink) |-> $past(vbus_valid) && $past(cc_stable);
    endproperty
    a_snk_attach_vbus: assert property (p_snk_attach_vbus)
        else $error("sink attached without bus power or CC settle");

    property p_vbus_low_drops;
        !vbus_sync |=> !vbus_valid;
    endproperty
    a_vbus_low_drops: assert property (p_vbus_low_drops)
        else $error("bus power valid while sensed low");

    property p_share_split;
        counting |-> (state_ff == cc_timing_pkg::ST_SOURCE) == (toggle_cnt_ff < share_lim);
    endproperty
    a_share_split: assert property (p_share_split)
        else $error("role does not match source share");

    property p_period_bound;
        toggle_cnt_ff < CW'(PERIOD_CYC);
    endproperty
    a_period_bound: assert property (p_period_bound)
        else $error("toggle count past period");

    property p_wrap_to_source;
        counting && state_ff == cc_timing_pkg::ST_SINK && !cc_attach &&
            toggle_cnt_ff == CW'(PERIOD_CYC - 1)
            |=> state_ff == cc_timing_pkg::ST_SOURCE && toggle_cnt_ff == `CNT_ZERO;
    endproperty
    a_wrap_to_source: assert property (p_wrap_to_source)
        else $error("dual role did not return to source");

    property p_mgmt_ready_time;
        en_active && mgmt_cnt_ff == CW'(MGMT_LAST) |=> mgmt_ready_ff;
    endproperty
    a_mgmt_ready_time: assert property (p_mgmt_ready_time)
        else $error("management port not ready in time");

    property p_mgmt_not_early;
        $rose(mgmt_ready_ff) |-> $past(mgmt_cnt_ff) == CW'(MGMT_LAST);
    endproperty
    a_mgmt_not_early: assert property (p_mgmt_not_early)
        else $error("management port ready early");

    property p_mode_held;
        state_ff != cc_timing_pkg::ST_SAMPLE |=> $stable(mode_ff);
    endproperty
    a_mode_held: assert property (p_mode_held)
        else $error("role mode changed after sampling");

    c_src_attach: cover property (nxt_state == cc_timing_pkg::ST_ATT_SRC);
    c_snk_attach: cover property (nxt_state == cc_timing_pkg::ST_ATT_SNK);
    c_dual_toggle: cover property (counting && state_ff == cc_timing_pkg::ST_SINK);
    c_mgmt_ready: cover property ($rose(mgmt_ready_ff));

endmodule : cc_timing_core

// *** verification/remote_port_model.sv ***
module remote_port_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Commands from the bench
    input wire logic attach_in,
    input wire logic flip_in,
    input wire logic supply_in,
    // Termination presented by the device
    input wire logic device_sink_in,
    // Pins towards the device
    output logic [1:0] cc_detect_out,
    output logic bus_power_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Only one CC wire carries the far termination; which one follows the plug flip
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            cc_detect_out <= 2'h0;
        else
            cc_detect_out <= attach_in ? (flip_in ? 2'h2 : 2'h1) : 2'h0;
    end

    // A far source powers the bus only once it sees a sink pull-down
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            bus_power_out <= 1'b0;
        else
            bus_power_out <= attach_in & supply_in & device_sink_in;
    end
endmodule : remote_port_model

// *** verification/test_typec_cc_timing_control.sv ***
module test_typec_cc_timing_control;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SETTLE = 40;
    localparam int VBUS = 10;
    localparam int PERIOD = 100;
    localparam int MGMT = 20;
    localparam int HOST_BIT_CYC = 400;

    typedef struct packed {
        logic hi;
        logic lo;
        logic src;
        logic snk;
        logic dual;
    } role_row_t;

    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic enable_n_in = 1'b0;
    logic role_pin_high_in = 1'b0;
    logic role_pin_low_in = 1'b0;
    logic [1:0] cc_detect;
    logic bus_power;
    logic [1:0] cc_settle_time_field_in = 2'h0;
    logic [1:0] source_share_field_in = 2'h0;
    logic attach = 1'b0;
    logic flip = 1'b0;
    logic supply = 1'b0;
    logic present_source_out;
    logic present_sink_out;
    logic dual_role_out;
    cc_timing_pkg::cc_status_t status_out;
    logic mgmt_ready_out;
    int errors = 0;
    int samples_checked = 0;
    role_row_t rows [3];
    int ones;
    int n;
    logic prev;

    initial
    begin
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end

    cc_timing_core #(
        .SETTLE_CYC_00(SETTLE), .SETTLE_CYC_01(SETTLE), .SETTLE_CYC_10(SETTLE),
        .SETTLE_CYC_11(SETTLE), .VBUS_CYC(VBUS), .PERIOD_CYC(PERIOD), .MGMT_CYC(MGMT)
    ) u_cc_timing_core (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .enable_n_in(enable_n_in),
        .role_pin_high_in(role_pin_high_in), .role_pin_low_in(role_pin_low_in),
        .cc_detect_in(cc_detect), .bus_power_sense_input_in(bus_power),
        .cc_settle_time_field_in(cc_settle_time_field_in),
        .source_share_field_in(source_share_field_in),
        .present_source_out(present_source_out), .present_sink_out(present_sink_out),
        .dual_role_out(dual_role_out), .status_out(status_out),
        .mgmt_ready_out(mgmt_ready_out)
    );

    remote_port_model u_remote_port_model (
        .clk_in(ref_clk_in), .rst_n_in(rst_n_in), .attach_in(attach), .flip_in(flip),
        .supply_in(supply), .device_sink_in(present_sink_out),
        .cc_detect_out(cc_detect), .bus_power_out(bus_power)
    );

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Advance n rising edges, then settle on the falling edge for sampling
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask : cyc

    task automatic restart(input logic hi, input logic lo);
        @(posedge ref_clk_in);
        rst_n_in <= 1'b0;
        role_pin_high_in <= hi;
        role_pin_low_in <= lo;
        attach <= 1'b0;
        supply <= 1'b0;
        cyc(1);
        check(8'({present_source_out, present_sink_out, dual_role_out}), 8'h00);
        check(8'(mgmt_ready_out), 8'h00);
        check(8'(status_out), 8'h00);
        repeat (1) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        cyc(8);
    endtask : restart

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    initial
    begin
        #(25 * 20_000);
        errors++;
        print_verdict();
    end

    initial
    begin
        rows[0] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        rows[1] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        rows[2] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        cyc(2);
        foreach (rows[i])
        begin
            restart(rows[i].hi, rows[i].lo);
            check(8'({present_source_out, present_sink_out, dual_role_out}),
                  8'({rows[i].src, rows[i].snk, rows[i].dual}));
            // The pin is read once; a later change must not set or clear dual_role_out
            role_pin_high_in <= ~rows[i].hi;
            role_pin_low_in <= rows[i].hi;
            cyc(10);
            check(8'(dual_role_out), 8'(rows[i].dual));
        end
        // Management port readiness and enable acting as a soft reset
        restart(1'b1, 1'b0);
        check(8'(mgmt_ready_out), 8'h00);
        cyc(MGMT + 6);
        check(8'(mgmt_ready_out), 8'h01);
        enable_n_in <= 1'b1;
        cyc(5);
        check(8'(mgmt_ready_out), 8'h00);
        enable_n_in <= 1'b0;
        cyc(MGMT - 2);
        check(8'(mgmt_ready_out), 8'h00);
        // Deadline: the full ready time after the pin change, nothing more
        cyc(2);
        check(8'(mgmt_ready_out), 8'h01);
        // A standard-mode host spends a whole bit time per access; ready must stand
        cyc(HOST_BIT_CYC);
        check(8'(mgmt_ready_out), 8'h01);
        // Source attach on CC2 with a one-cycle dropout restarting the settle count
        flip <= 1'b1;
        attach <= 1'b1;
        cyc(20);
        attach <= 1'b0;
        cyc(0);
        attach <= 1'b1;
        cyc(SETTLE - 4);
        check(8'(status_out.attached), 8'h00);
        cyc(12);
        check(8'(status_out), 8'h0a);
        check(8'(present_source_out), 8'h01);
        // Sink attach waits for bus power, which itself must hold unbroken
        restart(1'b0, 1'b1);
        flip <= 1'b0;
        attach <= 1'b1;
        cyc(SETTLE + 15);
        check(8'(status_out.attached), 8'h00);
        supply <= 1'b1;
        cyc(5);
        supply <= 1'b0;
        cyc(0);
        supply <= 1'b1;
        cyc(VBUS + 1);
        check(8'(status_out.vbus_valid), 8'h00);
        cyc(12);
        check(8'(status_out), 8'h0d);
        supply <= 1'b0;
        cyc(8);
        check(8'(status_out.attached), 8'h00);
        // Dual role: period and source share for every share code
        restart(1'b0, 1'b0);
        for (int code = 0; code < 4; code++)
        begin
            source_share_field_in <= 2'(code);
            cyc(PERIOD + 5);
            prev = present_source_out;
            n = 0;
            while (!(prev === 1'b0 && present_source_out === 1'b1) && n < 3 * PERIOD)
            begin
                prev = present_source_out;
                cyc(0);
                n++;
            end
            ones = 0;
            for (int k = 0; k < PERIOD; k++)
            begin
                ones += (present_source_out === 1'b1) ? 1 : 0;
                prev = present_source_out;
                cyc(0);
            end
            check(8'(ones), 8'(PERIOD * (30 + 10 * code) / 100));
            check({6'h00, prev, present_source_out}, 8'h01);
            check(8'(present_sink_out), 8'h00);
        end
        print_verdict();
    end
endmodule : test_typec_cc_timing_control
